//--- usf_status.sv
`timescale 1ns/10ps
// Purpose: status flags, fault latches, state code and pin readback
// Assumes: burst engine and memory loader run on CLK_SYS; pins are asynchronous
// Notes: a fault clear never hides an event of the same cycle
module usf_status
    import usf_pkg::*;
#(
    parameter logic [USF_STUCK_W-1:0] STUCK_LIMIT = USF_STUCK_LIMIT_DEF
) (
    input wire logic CLK_SYS,                       // 50 MHz system clock
    input wire logic RST,                           // synchronous reset, active high
    input wire logic REG_AT_TARGET,                 // regulator at programmed level
    input wire logic BURST_ACTIVE,                  // burst in progress
    input wire logic PULSE_EDGE,                    // one drive pulse emitted
    input wire logic [usf_pkg::USF_PULSE_W-1:0] PULSE_CFG, // configured pulse count
    input wire logic DRIVE_OUT,                     // drive output level during burst
    input wire logic NVM_LOAD_DONE,                 // memory load finished pulse
    input wire logic NVM_CRC_OK,                    // checksum result with done
    input wire logic SLEEP_REQ,                     // enter sleep
    input wire logic STANDBY_REQ,                   // enter standby
    input wire logic FAULT_CLR,                     // clear all latched faults
    input wire logic DRIVE_CTRL_PIN_A,              // drive control pin a
    input wire logic DRIVE_CTRL_PIN_B,              // drive control pin b
    input wire logic ZERO_CROSS_PIN,                // zero crossing output level
    input wire logic ECHO_IRQ_PIN,                  // echo interrupt output level
    output usf_pkg::usf_err_t ERR_STATUS,           // supply ready and faults
    output usf_pkg::usf_state_t DEV_STATE,          // operating state code
    output usf_pkg::usf_pins_t PIN_STATUS           // pin levels
);
    import usf_pkg::*;

    // ****************************************
    // pin readback
    // ****************************************
    logic [3:0] pins_sync;

    usf_pin_sync #(
        .W(4)
    ) u_sync (
        .clk(CLK_SYS),
        .rst(RST),
        .din({DRIVE_CTRL_PIN_A, DRIVE_CTRL_PIN_B, ZERO_CROSS_PIN, ECHO_IRQ_PIN}),
        .dout(pins_sync)
    );

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            PIN_STATUS <= USF_PIN_RST;
        end else begin
            PIN_STATUS.drive_ctrl_pin_a <= pins_sync[3];
            PIN_STATUS.drive_ctrl_pin_b <= pins_sync[2];
            PIN_STATUS.zero_cross_pin <= pins_sync[1];
            PIN_STATUS.echo_irq_pin <= pins_sync[0];
        end
    end

    // ****************************************
    // supply ready
    // ****************************************
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ERR_STATUS.drive_supply_ready <= 1'b0;
        end else begin
            ERR_STATUS.drive_supply_ready <= REG_AT_TARGET;
        end
    end

    // ****************************************
    // pulse counting
    // ****************************************
    logic burst_d;
    logic [USF_PULSE_W-1:0] pulse_cnt;
    logic burst_end;
    logic short_burst;
    logic [USF_PULSE_W:0] pulse_total;

    assign burst_end = burst_d && !BURST_ACTIVE;
    // count the edge landing in the final cycle too; the extra bit keeps a full
    // count plus that edge from wrapping to zero and raising a false fault
    assign pulse_total = {1'b0, pulse_cnt} + (USF_PULSE_W+1)'(PULSE_EDGE);
    assign short_burst = burst_end && (pulse_total < {1'b0, PULSE_CFG});

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            burst_d <= 1'b0;
        end else begin
            burst_d <= BURST_ACTIVE;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            pulse_cnt <= '0;
        end else if (!BURST_ACTIVE) begin
            pulse_cnt <= '0;
        end else if (PULSE_EDGE && pulse_cnt != '1) begin
            pulse_cnt <= pulse_cnt + USF_PULSE_W'(1);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ERR_STATUS.pulse_count_fault <= 1'b0;
        end else if (short_burst) begin
            ERR_STATUS.pulse_count_fault <= 1'b1;
        end else if (FAULT_CLR) begin
            ERR_STATUS.pulse_count_fault <= 1'b0;
        end
    end

    // ****************************************
    // stuck drive detection
    // ****************************************
    // drive output is same-domain logic, so no synchroniser here
    logic drive_d;
    logic [USF_STUCK_W-1:0] still_cnt;
    logic stuck_hit;

    assign stuck_hit = BURST_ACTIVE && (DRIVE_OUT == drive_d) && (still_cnt == STUCK_LIMIT);

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            drive_d <= 1'b0;
            still_cnt <= '0;
        end else begin
            drive_d <= DRIVE_OUT;
            if (!BURST_ACTIVE || DRIVE_OUT != drive_d) begin
                still_cnt <= '0;
            end else if (still_cnt != STUCK_LIMIT) begin
                still_cnt <= still_cnt + USF_STUCK_W'(1);
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ERR_STATUS.stuck_drive_fault <= 1'b0;
        end else if (stuck_hit) begin
            ERR_STATUS.stuck_drive_fault <= 1'b1;
        end else if (FAULT_CLR) begin
            ERR_STATUS.stuck_drive_fault <= 1'b0;
        end
    end

    // ****************************************
    // memory checksum
    // ****************************************
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ERR_STATUS.nvm_checksum_fault <= 1'b0;
        end else if (NVM_LOAD_DONE && !NVM_CRC_OK) begin
            ERR_STATUS.nvm_checksum_fault <= 1'b1;
        end else if (FAULT_CLR) begin
            ERR_STATUS.nvm_checksum_fault <= 1'b0;
        end
    end

    // ****************************************
    // operating state
    // ****************************************
    // burst outranks the low power requests so a running burst is always reported
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            DEV_STATE <= USF_LISTEN;
        end else if (BURST_ACTIVE) begin
            DEV_STATE <= USF_BURST;
        end else if (SLEEP_REQ) begin
            DEV_STATE <= USF_SLEEP;
        end else if (STANDBY_REQ) begin
            DEV_STATE <= USF_STANDBY;
        end else begin
            DEV_STATE <= USF_LISTEN;
        end
    end
endmodule

//--- usf_pkg.sv
// Purpose: constants and types for the ultrasonic driver status flag block
// Assumes: one system clock, synchronous active-high reset
// Notes: no register bus; status leaves the block as plain ports
//
// Operation
// - drive_supply_ready is raised once the drive regulator reports its target level.
// - pulse_count_fault is set when a burst ends before the configured pulse count.
// - stuck_drive_fault is set when a drive output fails to toggle while pulsing.
// - nvm_checksum_fault is set when the memory load checksum check fails.
// - the operating state reads 00 listen, 01 burst, 10 standby, 11 sleep.
// - both drive control pin levels are readable status bits.
// - the zero crossing pin level is a readable status bit.
// - the echo interrupt pin level is a readable status bit.
package usf_pkg;

    // ****************************************
    // state codes and widths
    // ****************************************
    typedef enum logic [1:0] {
        USF_LISTEN  = 2'h0,
        USF_BURST   = 2'h1,
        USF_STANDBY = 2'h2,
        USF_SLEEP   = 2'h3
    } usf_state_t;

    localparam int unsigned USF_PULSE_W = 6;
    localparam int unsigned USF_STUCK_W = 8;
    localparam logic [USF_STUCK_W-1:0] USF_STUCK_LIMIT_DEF = 8'hFF;
    localparam int unsigned USF_SYNC_STAGES = 3;
    localparam logic [3:0] USF_PIN_RST = 4'h0;

    typedef struct packed {
        logic drive_supply_ready;
        logic pulse_count_fault;
        logic stuck_drive_fault;
        logic nvm_checksum_fault;
    } usf_err_t;

    typedef struct packed {
        logic drive_ctrl_pin_a;
        logic drive_ctrl_pin_b;
        logic zero_cross_pin;
        logic echo_irq_pin;
    } usf_pins_t;

endpackage

//--- usf_pin_sync.sv
`timescale 1ns/10ps
// Purpose: three-stage synchroniser with agreement filter for pin levels
// Assumes: inputs are asynchronous to CLK_SYS
// Notes: output changes only when stages two and three agree
module usf_pin_sync #(
    parameter int unsigned W = 4
) (
    input wire logic clk,          // system clock
    input wire logic rst,          // synchronous reset
    input wire logic [W-1:0] din,  // raw pin levels
    output logic [W-1:0] dout      // filtered levels
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // first stage is read only by the second
    always_ff @(posedge clk) begin
        if (rst) begin
            dout <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    dout[i] <= s3[i];
                end
            end
        end
    end
endmodule

//--- usf_status_monitor.sv
// Purpose: timing checks on the status flag block ports
// Assumes: one clock, synchronous active-high reset
// Notes: helper counters rebuild pulse and stuck counts from inputs
`timescale 1ns/10ps
module usf_status_monitor
    import usf_pkg::*;
#(
    parameter logic [USF_STUCK_W-1:0] STUCK_LIMIT = USF_STUCK_LIMIT_DEF
) (
    input wire logic CLK_SYS, RST, REG_AT_TARGET, BURST_ACTIVE, PULSE_EDGE, // controls
    input wire logic [USF_PULSE_W-1:0] PULSE_CFG, // pulse count
    input wire logic DRIVE_OUT, NVM_LOAD_DONE, NVM_CRC_OK, SLEEP_REQ, FAULT_CLR, // events
    input wire logic DRIVE_CTRL_PIN_A, DRIVE_CTRL_PIN_B, ZERO_CROSS_PIN, ECHO_IRQ_PIN, // pins
    input wire usf_err_t ERR_STATUS, // flags
    input wire usf_state_t DEV_STATE, // state
    input wire usf_pins_t PIN_STATUS // pin readback
);
    logic [6:0] n_pulse;
    logic [8:0] n_same;
    logic last_drive;
    wire [3:0] pins = {DRIVE_CTRL_PIN_A, DRIVE_CTRL_PIN_B, ZERO_CROSS_PIN, ECHO_IRQ_PIN};
    // seven bits, saturating, so the count never wraps back under any setting
    always_ff @(posedge CLK_SYS) begin
        if (RST || !BURST_ACTIVE) n_pulse <= '0;
        else if (n_pulse != 7'h7F) n_pulse <= n_pulse + 7'(PULSE_EDGE);
    end
    always_ff @(posedge CLK_SYS) begin
        last_drive <= DRIVE_OUT;
        if (RST || !BURST_ACTIVE || DRIVE_OUT != last_drive) n_same <= '0;
        else if (n_same != 9'h1FF) n_same <= n_same + 9'h001;
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    sequence s_pins_quiet; $stable(pins) [*7]; endsequence
    // a pulse in the cycle the burst drops still counts toward the total
    sequence s_short_burst;
        $fell(BURST_ACTIVE) && ({1'b0, n_pulse} + 8'(PULSE_EDGE)) < 8'(PULSE_CFG);
    endsequence
    property p_ready; 1'b1 |=> ERR_STATUS.drive_supply_ready == $past(REG_AT_TARGET); endproperty
    property p_short; s_short_burst |=> ERR_STATUS.pulse_count_fault; endproperty
    property p_stuck;
        BURST_ACTIVE && DRIVE_OUT == last_drive && n_same >= 9'(STUCK_LIMIT) |=>
            ERR_STATUS.stuck_drive_fault;
    endproperty
    property p_crc; NVM_LOAD_DONE && !NVM_CRC_OK |=> ERR_STATUS.nvm_checksum_fault; endproperty
    property p_burst; BURST_ACTIVE |=> DEV_STATE == USF_BURST; endproperty
    property p_sleep; !BURST_ACTIVE && SLEEP_REQ |=> DEV_STATE == USF_SLEEP; endproperty
    property p_pins; s_pins_quiet |-> PIN_STATUS == pins; endproperty
    property p_hold;
        ERR_STATUS[2:0] != 3'h0 && !FAULT_CLR |=>
            (ERR_STATUS[2:0] & $past(ERR_STATUS[2:0])) == $past(ERR_STATUS[2:0]);
    endproperty
    a_ready: assert property (p_ready) else $error("ready flag late");
    a_short: assert property (p_short) else $error("short burst missed");
    a_stuck: assert property (p_stuck) else $error("stuck drive missed");
    a_crc: assert property (p_crc) else $error("checksum fault missed");
    a_burst: assert property (p_burst) else $error("burst code wrong");
    a_sleep: assert property (p_sleep) else $error("sleep code wrong");
    a_pins: assert property (p_pins) else $error("pin level wrong");
    a_hold: assert property (p_hold) else $error("fault flag dropped");
endmodule
bind usf_status usf_status_monitor #(.STUCK_LIMIT(STUCK_LIMIT)) mon_u (.*);

//--- usf_host_model.sv
// Purpose: host that polls the status flags and judges them
// Assumes: status is sampled on the system clock
// Notes: any set fault counts as irregular
`timescale 1ns/10ps
module usf_host_model
    import usf_pkg::*;
#(
    parameter int POLL = 8
) (
    input wire logic clk, // system clock
    input wire logic rst, // reset
    input wire usf_err_t status, // flags read
    output logic irregular // fault seen at last poll
);
    int cnt;
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= 0; // first poll after any reset is the start-up read
            irregular <= 1'h0;
        end else begin
            cnt <= (cnt == POLL - 1) ? 0 : cnt + 1;
            if (cnt == 0) irregular <= |status[2:0];
        end
    end
endmodule

//--- usf_status_bench.sv
// Purpose: directed tests of the status flag block
// Assumes: stuck limit shortened to four cycles
// Notes: inputs change at the falling edge
`timescale 1ns/10ps
module usf_status_bench;
    import usf_pkg::*;
    logic CLK_SYS = '0, RST = '1, REG_AT_TARGET = '0, BURST_ACTIVE = '0, PULSE_EDGE = '0;
    logic [USF_PULSE_W-1:0] PULSE_CFG = '0;
    logic DRIVE_OUT = '0, NVM_LOAD_DONE = '0, NVM_CRC_OK = '0, SLEEP_REQ = '0;
    logic STANDBY_REQ = '0, FAULT_CLR = '0, DRIVE_CTRL_PIN_A = '0, DRIVE_CTRL_PIN_B = '0;
    logic ZERO_CROSS_PIN = '0, ECHO_IRQ_PIN = '0, irregular;
    usf_err_t ERR_STATUS;
    usf_state_t DEV_STATE;
    usf_pins_t PIN_STATUS;
    int mismatches = 0, n_checks = 0, ticks = 0;
    logic [2:0] req [4] = '{3'h0, 3'h1, 3'h3, 3'h6};
    usf_state_t st_exp [4] = '{USF_LISTEN, USF_STANDBY, USF_SLEEP, USF_BURST};
    always #10 CLK_SYS = ~CLK_SYS;
    usf_status #(.STUCK_LIMIT(8'h04)) dut_u (.*);
    usf_host_model host_u (.clk(CLK_SYS), .rst(RST), .status(ERR_STATUS), .irregular(irregular));
    task cyc(int n); repeat (n) @(negedge CLK_SYS); endtask
    task chk(logic [3:0] seen, logic [3:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task final_report();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task burst(int np, int cfg, logic tog);
        BURST_ACTIVE = 1'h1;
        PULSE_CFG = USF_PULSE_W'(cfg);
        cyc(1);
        repeat (np) begin
            PULSE_EDGE = 1'h1;
            DRIVE_OUT ^= tog;
            cyc(1);
        end
        PULSE_EDGE = 1'h0;
        BURST_ACTIVE = 1'h0;
        cyc(2);
    endtask
    task clr(logic clear, logic load, logic ok);
        FAULT_CLR = clear;
        NVM_LOAD_DONE = load;
        NVM_CRC_OK = ok;
        cyc(1);
        {FAULT_CLR, NVM_LOAD_DONE} = 2'h0;
        cyc(1);
    endtask
    always @(posedge CLK_SYS) begin
        ticks++;
        if (ticks == 2000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        cyc(4);
        chk(ERR_STATUS | 4'(DEV_STATE) | PIN_STATUS, 4'h0);
        RST = 1'h0;
        REG_AT_TARGET = 1'h1;
        cyc(2);
        chk(ERR_STATUS, 4'h8);
        REG_AT_TARGET = 1'h0;
        for (int i = 0; i < 4; i++) begin
            {BURST_ACTIVE, SLEEP_REQ, STANDBY_REQ} = req[i];
            cyc(2);
            chk(4'(DEV_STATE), 4'(st_exp[i]));
        end
        {BURST_ACTIVE, SLEEP_REQ, STANDBY_REQ} = 3'h0;
        cyc(2);
        $display("supply and state tests done");
        burst(2, 3, 1'h1);
        chk(ERR_STATUS, 4'h4);
        cyc(6);
        chk(ERR_STATUS, 4'h4);
        clr(1'h1, 1'h0, 1'h0);
        burst(3, 3, 1'h1);
        chk(ERR_STATUS, 4'h0);
        burst(8, 8, 1'h0);
        chk(ERR_STATUS, 4'h2);
        clr(1'h1, 1'h0, 1'h0);
        clr(1'h0, 1'h1, 1'h1);
        chk(ERR_STATUS, 4'h0);
        clr(1'h1, 1'h1, 1'h0);
        chk(ERR_STATUS, 4'h1);
        cyc(10);
        chk(4'(irregular), 4'h1);
        $display("fault tests done");
        RST = 1'h1;
        cyc(2);
        RST = 1'h0;
        cyc(1);
        chk(ERR_STATUS, 4'h0);
        chk(4'(irregular), 4'h0);
        $display("reset test done");
        for (int i = 0; i < 5; i++) begin
            {DRIVE_CTRL_PIN_A, DRIVE_CTRL_PIN_B, ZERO_CROSS_PIN, ECHO_IRQ_PIN} = 4'h8 >> i;
            cyc(8);
            chk(PIN_STATUS, 4'h8 >> i);
        end
        $display("pin tests done");
        final_report();
    end
endmodule
